/* File: hdl/sbc_regs.svh */
/*
  Register offsets, field positions, reset values and timing counts for the
  start-up and burst entry sequencer. Assumes byte addressing on a 32-bit
  bus, with one aligned word per register.
*/
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH

// byte offsets
`define SBC_FB_LEVELS 8'h00
`define SBC_PULSES 8'h04
`define SBC_REFLECT_THR 8'h08
`define SBC_SEARCH 8'h0c
`define SBC_SETPOINTS 8'h10
`define SBC_RAMP 8'h14
`define SBC_TIMERS 8'h18
`define SBC_BURST 8'h1c
`define SBC_BURST_PEAK 8'h20
`define SBC_HSMAX 8'h24
`define SBC_STATUS 8'h28
`define SBC_NUM_CFG 10

// field positions
`define SBC_LO10 9:0
`define SBC_HI10 25:16
`define SBC_LO16 15:0
`define SBC_HI16 31:16
`define SBC_LO8 7:0
`define SBC_MID10 19:10
`define SBC_TOP8 27:20
`define SBC_MID8 23:16

// reset values
`define SBC_FB_LEVELS_RST 32'h0020_0040
`define SBC_PULSES_RST 32'h0032_0064
`define SBC_REFLECT_THR_RST 32'h0180_0080
`define SBC_SEARCH_RST 32'h00c8_0020
`define SBC_SETPOINTS_RST 32'h0300_0100
`define SBC_RAMP_RST 32'h0040_0200
`define SBC_TIMERS_RST 32'h0064_1000
`define SBC_BURST_RST 32'h0803_e040
`define SBC_BURST_PEAK_RST 32'h0020_0040
`define SBC_HSMAX_RST 32'h0010_0800

// timing
`define SBC_CLK_NS 10
`define SBC_SLOW_TASK_NS 10000
`define SBC_SLOW_TASK_CYC (`SBC_SLOW_TASK_NS / `SBC_CLK_NS)
`define SBC_STEP 10'h001

`endif

/* File: hdl/sbc_pkg.sv */
/*
  Types for the start-up and burst entry sequencer.
  Assumes sbc_regs.svh for the numbers.
*/
package sbc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_CHECK = 4'b0001,
    ST_CHECK_OT = 4'b0010,
    ST_BANG = 4'b0011,
    ST_PRECHG = 4'b0100,
    ST_HS_ON = 4'b0101,
    ST_WAIT_ZC = 4'b0110,
    ST_ZV = 4'b0111,
    ST_SLEEP = 4'b1000,
    ST_FAULT = 4'b1001
  } sbc_state_type;
  typedef logic [9:0] sbc_level_type;
endpackage

/* File: hdl/sbc_tick.sv */
/*
  Divider giving a one-cycle slow-task enable.
  Assumes one clock and asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sbc_tick #(
  parameter int DIV = 1000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // enable out
  output logic tick
);
  logic [15:0] cnt_reg;

  // free-running count; tick marks each wrap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_reg == 16'(DIV - 1)) begin
      cnt_reg <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/sbc_oneshot.sv */
/*
  One-shot pulse timer for the lower switch drive.
  Assumes start is a one-cycle pulse and len is at least one.
*/
`timescale 1ns/1ps
`default_nettype none
module sbc_oneshot #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request
  input wire logic start,
  input wire logic [W-1:0] len,
  // pulse
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_reg;

  // busy for exactly len cycles after start, done in the cycle after
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      cnt_reg <= len;
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy) begin
      cnt_reg <= cnt_reg - W'(1);
      busy <= (cnt_reg > W'(1));
      done <= (cnt_reg == W'(1));
    end else begin
      done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/sbc_startup_ctrl.sv */
/*
  Output start-up sequencer and burst entry decision for a half-bridge
  flyback controller, with a classic Wishbone register slave.
  Assumes all sense inputs are synchronous to CLOCK and the analogue
  levels arrive already digitised.
*/
// Overview of operation
// - start request after reset, restart, supply up
// - check brown-in, no overvoltage, feedback, temperature
// - first three within window, then temperature
// - any failed check falls back to bang-bang regulation
// - compute upper switch max on-time from input
// - one first lower pulse precharges bootstrap
// - fixed pulse until threshold, then shorten it
// - count switching cycles while searching
// - missing zero crossing: next pulse after timeout
// - too many search cycles: output short fault
// - peak starts at first overcurrent setpoint, held
// - above threshold step peak toward target
// - target rises by nominal over ramp each tick
// - clamp setpoint to start-up ceiling
// - above valley threshold use continuous scheme
// - hand over when feedback setting drops below
// - start-up too long: timeout fault
// - feedback below burst level: suppress, sleep
// - burst level from setpoint by control law
// - in burst use fixed minimum peak setting
// - recharge supply once at burst entry
`include "sbc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sbc_startup_ctrl #(
  parameter int SLOW_DIV = `SBC_SLOW_TASK_CYC
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // supply and start-up conditions
  input wire logic SUPPLY_ON,
  input wire logic RESTART_REQ,
  input wire logic BROWN_IN_OK,
  input wire logic NO_INPUT_OV,
  input wire logic OVERTEMP_OK,
  // digitised sense levels
  input wire logic [9:0] VIN_CODE,
  input wire logic [9:0] FB_CODE,
  input wire logic [9:0] ZCD_CODE,
  input wire logic [9:0] FB_SETPOINT,
  // power stage events
  input wire logic ZCD_DET,
  input wire logic CS_TRIP,
  // gate drives and status
  output logic UPPER_GATE,
  output logic LOWER_GATE,
  output logic [9:0] PEAK_SET,
  output logic CRM_MODE,
  output logic FB_CTRL,
  output logic BANG_BANG,
  output logic SLEEP,
  output logic HV_CELL_PULSE,
  output logic OUT_SHORT_FAULT,
  output logic STARTUP_TO_FAULT,
  output logic SHUNT_FAULT
);
  localparam logic [31:0] CFG_RST [`SBC_NUM_CFG] = '{
    `SBC_FB_LEVELS_RST, `SBC_PULSES_RST, `SBC_REFLECT_THR_RST, `SBC_SEARCH_RST,
    `SBC_SETPOINTS_RST, `SBC_RAMP_RST, `SBC_TIMERS_RST, `SBC_BURST_RST,
    `SBC_BURST_PEAK_RST, `SBC_HSMAX_RST};

  sbc_pkg::sbc_state_type state_reg;
  logic [31:0] cfg_reg [`SBC_NUM_CFG];
  logic ack_reg, supply_prev_reg, start_req, locked, slow_tick, os_start, os_busy, os_done;
  logic [3:0] idx;
  logic idx_ok, wr_en, cond123, startup, search, hs_entry;
  logic [15:0] win_cnt_reg, sto_cnt_reg, zc_to_cnt_reg, hs_cnt_reg, hs_max_reg;
  logic [15:0] os_len, zv_len, ramp_rem_reg;
  logic [7:0] search_cnt_reg;
  logic [9:0] peak_reg, target_reg, burst_thr, burst_peak, ceiling;
  logic [27:0] law_prod;
  logic [17:0] vin_prod;

  // bus decode; unmapped offsets answer with zero and drop writes
  assign idx = WB_ADR_I[5:2];
  assign idx_ok = (WB_ADR_I[7:6] == 2'b00) && (WB_ADR_I[1:0] == 2'b00) &&
                  (idx < 4'(`SBC_NUM_CFG));
  assign locked = !(state_reg inside {sbc_pkg::ST_IDLE, sbc_pkg::ST_BANG,
                                      sbc_pkg::ST_FAULT, sbc_pkg::ST_SLEEP});
  assign wr_en = ack_reg && WB_CYC_I && WB_STB_I && WB_WE_I && idx_ok && !locked;
  assign WB_ACK_O = ack_reg;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ack_reg <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      ack_reg <= WB_CYC_I && WB_STB_I && !ack_reg;
      if (WB_CYC_I && WB_STB_I && !ack_reg) begin
        if (idx_ok) begin
          WB_DAT_O <= cfg_reg[idx];
        end else if (WB_ADR_I == `SBC_STATUS) begin
          WB_DAT_O <= {6'h00, peak_reg, 5'h00, locked, SHUNT_FAULT, STARTUP_TO_FAULT,
                       OUT_SHORT_FAULT, SLEEP, FB_CTRL, CRM_MODE, state_reg};
        end else begin
          WB_DAT_O <= 32'h0000_0000;
        end
      end
    end
  end

  // configuration words with byte lanes; frozen while a sequence runs
  for (genvar g = 0; g < `SBC_NUM_CFG; g++) begin : g_cfg
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
        cfg_reg[g] <= CFG_RST[g];
      end else if (wr_en && idx == 4'(g)) begin
        for (int b = 0; b < 4; b++) begin
          if (WB_SEL_I[b]) begin
            cfg_reg[g][8*b +: 8] <= WB_DAT_I[8*b +: 8];
          end
        end
      end
    end
  end

  sbc_tick #(.DIV(SLOW_DIV)) u_tick (
    .clk(CLOCK),
    .rst(SYS_RST),
    .tick(slow_tick)
  );

  sbc_oneshot #(.W(16)) u_lower (
    .clk(CLOCK),
    .rst(SYS_RST),
    .start(os_start),
    .len(os_len),
    .busy(os_busy),
    .done(os_done)
  );

  // start request on supply rising past turn-on, or restart with supply up
  assign start_req = (SUPPLY_ON && !supply_prev_reg) || (RESTART_REQ && SUPPLY_ON);
  assign cond123 = BROWN_IN_OK && NO_INPUT_OV &&
                   (FB_CODE > cfg_reg[0][`SBC_LO10]);
  assign startup = (state_reg inside {sbc_pkg::ST_PRECHG, sbc_pkg::ST_HS_ON,
                                      sbc_pkg::ST_WAIT_ZC, sbc_pkg::ST_ZV}) && !FB_CTRL;
  assign search = startup && (ZCD_CODE <= cfg_reg[2][`SBC_LO10]);
  assign ceiling = cfg_reg[4][`SBC_HI10];

  // burst level by the control law: sp * frac * fb_max + fb_min
  assign law_prod = 28'(cfg_reg[7][`SBC_LO10]) * 28'(cfg_reg[7][`SBC_TOP8]) *
                    28'(cfg_reg[7][`SBC_MID10]);
  assign burst_thr = law_prod[27:18] + cfg_reg[0][`SBC_HI10];
  assign burst_peak = cfg_reg[8][`SBC_LO10] + cfg_reg[8][`SBC_HI10];

  // fixed pulse until the reflected level passes threshold, then shorter
  always_comb begin
    zv_len = cfg_reg[1][`SBC_HI16];
    if (ZCD_CODE > cfg_reg[2][`SBC_LO10]) begin
      if (zv_len > 16'(ZCD_CODE - cfg_reg[2][`SBC_LO10])) begin
        zv_len = zv_len - 16'(ZCD_CODE - cfg_reg[2][`SBC_LO10]);
      end else begin
        zv_len = 16'h0001;
      end
    end
  end

  // lower switch launches: first precharge pulse or zero-voltage pulse
  assign os_start = (state_reg == sbc_pkg::ST_CHECK_OT && OVERTEMP_OK) ||
                    (state_reg == sbc_pkg::ST_WAIT_ZC && (ZCD_DET ||
                     zc_to_cnt_reg >= cfg_reg[3][`SBC_HI16]) &&
                     search_cnt_reg <= cfg_reg[3][`SBC_LO8]);
  assign os_len = (state_reg == sbc_pkg::ST_CHECK_OT) ? cfg_reg[1][`SBC_LO16] : zv_len;
  assign hs_entry = os_done && (state_reg == sbc_pkg::ST_PRECHG ||
                    (state_reg == sbc_pkg::ST_ZV && !(FB_CTRL && FB_CODE < burst_thr)));
  assign vin_prod = 18'(VIN_CODE) * 18'(cfg_reg[9][`SBC_MID8]);

  // main sequence
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= sbc_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        sbc_pkg::ST_IDLE, sbc_pkg::ST_BANG, sbc_pkg::ST_FAULT, sbc_pkg::ST_SLEEP: begin
          if (start_req) begin
            state_reg <= sbc_pkg::ST_CHECK;
          end
        end
        sbc_pkg::ST_CHECK: begin
          if (cond123) begin
            state_reg <= sbc_pkg::ST_CHECK_OT;
          end else if (win_cnt_reg >= cfg_reg[6][`SBC_HI16]) begin
            state_reg <= sbc_pkg::ST_BANG;
          end
        end
        sbc_pkg::ST_CHECK_OT: begin
          state_reg <= OVERTEMP_OK ? sbc_pkg::ST_PRECHG : sbc_pkg::ST_BANG;
        end
        sbc_pkg::ST_PRECHG: begin
          if (os_done) begin
            state_reg <= sbc_pkg::ST_HS_ON;
          end
        end
        sbc_pkg::ST_HS_ON: begin
          if (hs_cnt_reg >= hs_max_reg) begin
            state_reg <= sbc_pkg::ST_FAULT;
          end else if (CS_TRIP) begin
            state_reg <= sbc_pkg::ST_WAIT_ZC;
          end
        end
        sbc_pkg::ST_WAIT_ZC: begin
          if (search_cnt_reg > cfg_reg[3][`SBC_LO8]) begin
            state_reg <= sbc_pkg::ST_FAULT;
          end else if (os_start) begin
            state_reg <= sbc_pkg::ST_ZV;
          end
        end
        sbc_pkg::ST_ZV: begin
          if (os_done) begin
            // the pulse that would follow is simply never launched
            state_reg <= hs_entry ? sbc_pkg::ST_HS_ON : sbc_pkg::ST_SLEEP;
          end
        end
        default: begin
          state_reg <= sbc_pkg::ST_IDLE;
        end
      endcase
      if (startup && sto_cnt_reg >= cfg_reg[6][`SBC_LO16]) begin
        state_reg <= sbc_pkg::ST_FAULT;
      end
    end
  end

  // window, timeout and on-time counters
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      supply_prev_reg <= 1'b0;
      win_cnt_reg <= 16'h0000;
      sto_cnt_reg <= 16'h0000;
      zc_to_cnt_reg <= 16'h0000;
      hs_cnt_reg <= 16'h0000;
      hs_max_reg <= 16'h0000;
    end else begin
      supply_prev_reg <= SUPPLY_ON;
      win_cnt_reg <= (state_reg != sbc_pkg::ST_CHECK) ? 16'h0000 :
                     win_cnt_reg + 16'(slow_tick);
      sto_cnt_reg <= !startup ? 16'h0000 : sto_cnt_reg + 16'(slow_tick);
      zc_to_cnt_reg <= (state_reg != sbc_pkg::ST_WAIT_ZC) ? 16'h0000 :
                       zc_to_cnt_reg + 16'h0001;
      hs_cnt_reg <= (state_reg != sbc_pkg::ST_HS_ON) ? 16'h0000 : hs_cnt_reg + 16'h0001;
      if (state_reg == sbc_pkg::ST_CHECK_OT) begin
        // linear inverse: higher input, shorter allowed on-time
        hs_max_reg <= (cfg_reg[9][`SBC_LO16] > 16'(vin_prod[17:8])) ?
                      cfg_reg[9][`SBC_LO16] - 16'(vin_prod[17:8]) : 16'h0001;
      end
    end
  end

  // search cycle count, cleared by any detected zero crossing
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      search_cnt_reg <= 8'h00;
    end else if (state_reg == sbc_pkg::ST_CHECK_OT || ZCD_DET) begin
      search_cnt_reg <= 8'h00;
    end else if (hs_entry && search && search_cnt_reg != 8'hff) begin
      search_cnt_reg <= search_cnt_reg + 8'h01;
    end
  end

  // target ramp: remainder accumulates nominal, one step per cycle of N
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      target_reg <= 10'h000;
      ramp_rem_reg <= 16'h0000;
    end else if (!startup) begin
      target_reg <= 10'h000;
      ramp_rem_reg <= 16'h0000;
    end else if (slow_tick) begin
      ramp_rem_reg <= ramp_rem_reg + 16'(cfg_reg[5][`SBC_LO10]);
    end else if (ramp_rem_reg >= cfg_reg[5][`SBC_HI16] && cfg_reg[5][`SBC_HI16] != 16'h0000) begin
      // spread over idle cycles, so nominal/ramp must stay below the tick
      ramp_rem_reg <= ramp_rem_reg - cfg_reg[5][`SBC_HI16];
      target_reg <= (target_reg == 10'h3ff) ? target_reg : target_reg + 10'h001;
    end
  end

  // peak setting per cycle
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      peak_reg <= 10'h000;
    end else if (state_reg == sbc_pkg::ST_SLEEP) begin
      peak_reg <= burst_peak;
    end else if (state_reg == sbc_pkg::ST_CHECK_OT) begin
      peak_reg <= (cfg_reg[4][`SBC_LO10] > ceiling) ? ceiling :
                  cfg_reg[4][`SBC_LO10];
    end else if (FB_CTRL) begin
      peak_reg <= FB_SETPOINT;
    end else if (hs_entry && !search) begin
      if (ZCD_CODE < target_reg) begin
        peak_reg <= (peak_reg >= ceiling - `SBC_STEP) ? ceiling :
                    peak_reg + `SBC_STEP;
      end else if (ZCD_CODE > target_reg && peak_reg >= `SBC_STEP) begin
        peak_reg <= peak_reg - `SBC_STEP;
      end
    end
  end

  // mode flags, faults and the one supply recharge
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      FB_CTRL <= 1'b0;
      CRM_MODE <= 1'b0;
      HV_CELL_PULSE <= 1'b0;
      OUT_SHORT_FAULT <= 1'b0;
      STARTUP_TO_FAULT <= 1'b0;
      SHUNT_FAULT <= 1'b0;
    end else begin
      HV_CELL_PULSE <= (state_reg == sbc_pkg::ST_ZV) && os_done && !hs_entry;
      if (state_reg == sbc_pkg::ST_CHECK_OT) begin
        FB_CTRL <= 1'b0;
        CRM_MODE <= 1'b0;
      end else begin
        if (startup && FB_SETPOINT < peak_reg) begin
          FB_CTRL <= 1'b1;
        end
        if (startup && ZCD_CODE > cfg_reg[2][`SBC_HI10]) begin
          CRM_MODE <= 1'b1;
        end
      end
      if (start_req) begin
        OUT_SHORT_FAULT <= 1'b0;
        STARTUP_TO_FAULT <= 1'b0;
        SHUNT_FAULT <= 1'b0;
      end
      if (state_reg == sbc_pkg::ST_WAIT_ZC && search_cnt_reg > cfg_reg[3][`SBC_LO8]) begin
        OUT_SHORT_FAULT <= 1'b1;
      end
      if (startup && sto_cnt_reg >= cfg_reg[6][`SBC_LO16]) begin
        STARTUP_TO_FAULT <= 1'b1;
      end
      if (state_reg == sbc_pkg::ST_HS_ON && hs_cnt_reg >= hs_max_reg) begin
        SHUNT_FAULT <= 1'b1;
      end
    end
  end

  assign UPPER_GATE = (state_reg == sbc_pkg::ST_HS_ON);
  assign LOWER_GATE = os_busy;
  assign PEAK_SET = peak_reg;
  assign BANG_BANG = (state_reg == sbc_pkg::ST_BANG);
  assign SLEEP = (state_reg == sbc_pkg::ST_SLEEP);

  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  property p_start_req;
    state_reg == sbc_pkg::ST_IDLE && SUPPLY_ON && !supply_prev_reg
      |=> state_reg == sbc_pkg::ST_CHECK;
  endproperty
  a_start_req: assert property (p_start_req) else $error("no check after supply up");

  property p_ot_after;
    state_reg == sbc_pkg::ST_CHECK ##1 state_reg == sbc_pkg::ST_CHECK_OT |-> $past(cond123);
  endproperty
  a_ot_after: assert property (p_ot_after) else $error("temp check too early");

  property p_fallback;
    state_reg == sbc_pkg::ST_CHECK_OT && !OVERTEMP_OK |=> BANG_BANG && !LOWER_GATE;
  endproperty
  a_fallback: assert property (p_fallback) else $error("no fallback on failed check");

  property p_first_pulse;
    state_reg == sbc_pkg::ST_CHECK_OT && OVERTEMP_OK
      |=> (LOWER_GATE && !UPPER_GATE)[*2];
  endproperty
  a_first_pulse: assert property (p_first_pulse) else $error("no precharge pulse");

  property p_clamp;
    startup && !FB_CTRL |-> peak_reg <= ceiling;
  endproperty
  a_clamp: assert property (p_clamp) else $error("peak above ceiling");

  property p_short;
    state_reg == sbc_pkg::ST_WAIT_ZC && search_cnt_reg > cfg_reg[3][`SBC_LO8]
      |=> OUT_SHORT_FAULT && state_reg == sbc_pkg::ST_FAULT;
  endproperty
  a_short: assert property (p_short) else $error("no short fault");

  property p_sleep_peak;
    SLEEP ##1 SLEEP |-> PEAK_SET == $past(burst_peak);
  endproperty
  a_sleep_peak: assert property (p_sleep_peak) else $error("burst peak wrong");

  property p_hv_once;
    $rose(SLEEP) |-> HV_CELL_PULSE ##1 !HV_CELL_PULSE;
  endproperty
  a_hv_once: assert property (p_hv_once) else $error("recharge not once");

  property p_handover;
    startup && state_reg != sbc_pkg::ST_CHECK_OT && FB_SETPOINT < peak_reg |=> FB_CTRL;
  endproperty
  a_handover: assert property (p_handover) else $error("no handover");
endmodule
`default_nettype wire

/* File: tb/sbc_stage_model.sv */
/*
  Power stage stand-in: answers the upper gate with a current trip and,
  when allowed, a zero crossing shortly after the gate drops.
  Assumes one clock and gate drives that come from the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module sbc_stage_model (
  // clock
  input wire logic clk,
  // gate and stage condition
  input wire logic upper_gate,
  input wire logic zc_enable,
  // sense events
  output logic cs_trip,
  output logic zcd_det
);
  int on_cnt = 0;
  int off_cnt = 0;
  // current reaches the peak a few cycles into the on-time; a shorted output never rings
  always @(posedge clk) begin
    on_cnt <= upper_gate ? on_cnt + 1 : 0;
    off_cnt <= upper_gate ? 0 : off_cnt + 1;
    cs_trip <= upper_gate && on_cnt == 3;
    zcd_det <= zc_enable && off_cnt == 2;
  end
  // quiet at time zero
  initial begin
    cs_trip = 1'b0;
    zcd_det = 1'b0;
  end
endmodule
`default_nettype wire

/* File: tb/sbc_startup_ctrl_bench.sv */
/*
  Self-checking bench for the start-up and burst entry sequencer.
  Assumes the register header and the power stage model beside it.
*/
`include "sbc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sbc_startup_ctrl_bench;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, zc_en = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, q, rd;
  logic sup = 1'b0, rsq = 1'b0, bi = 1'b1, nov = 1'b1, ot = 1'b1, cs, zc;
  logic [9:0] fb = 10'h100, zcd_lvl = 10'h000, fbsp = 10'h3ff, vin = 10'h200;
  logic ug_d = 1'b0;
  bit lk = 1'b0;
  logic ug, lg, continuous_resonant_scheme, fbc, bb, slp, hv, sf, tf, shf;
  logic [9:0] peak;
  logic [15:0] seed = 16'h0043;
  int n_mismatch = 0, n_tests = 0, n, n_hs = 0, n_hv = 0, hs0, hv0;
  int unsigned mdl[11] = '{`SBC_FB_LEVELS_RST, `SBC_PULSES_RST, `SBC_REFLECT_THR_RST,
    `SBC_SEARCH_RST, `SBC_SETPOINTS_RST, `SBC_RAMP_RST, `SBC_TIMERS_RST, `SBC_BURST_RST,
    `SBC_BURST_PEAK_RST, `SBC_HSMAX_RST, 0};
  // clock at 100 MHz
  always #5 clk = ~clk;
  sbc_startup_ctrl #(.SLOW_DIV(8)) sbc_startup_ctrl_i (.CLOCK(clk), .SYS_RST(rst),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
    .WB_DAT_I(dat), .WB_DAT_O(rd), .WB_ACK_O(ack), .SUPPLY_ON(sup), .RESTART_REQ(rsq),
    .BROWN_IN_OK(bi), .NO_INPUT_OV(nov), .OVERTEMP_OK(ot), .VIN_CODE(vin),
    .FB_CODE(fb), .ZCD_CODE(zcd_lvl), .FB_SETPOINT(fbsp), .ZCD_DET(zc), .CS_TRIP(cs),
    .UPPER_GATE(ug), .LOWER_GATE(lg), .PEAK_SET(peak), .CRM_MODE(continuous_resonant_scheme), .FB_CTRL(fbc),
    .BANG_BANG(bb), .SLEEP(slp), .HV_CELL_PULSE(hv), .OUT_SHORT_FAULT(sf),
    .STARTUP_TO_FAULT(tf), .SHUNT_FAULT(shf));
  sbc_stage_model sbc_stage_model_i (.clk(clk), .upper_gate(ug), .zc_enable(zc_en),
    .cs_trip(cs), .zcd_det(zc));
  // event counters: rising upper gate edges and supply recharge pulses
  always @(posedge clk) begin
    ug_d <= ug;
    if (ug === 1'b1 && ug_d === 1'b0) n_hs <= n_hs + 1;
    if (hv === 1'b1) n_hv <= n_hv + 1;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rd;
    if (n >= 50) check(1'b0, 1'b1);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (w && !lk && a < 8'h28) mdl[a >> 2] = d;
  endtask
  // one-cycle auto-restart request
  task automatic kick;
    rsq <= 1'b1;
    @(posedge clk);
    rsq <= 1'b0;
  endtask
  // bounded wait for a level from the design
  task automatic await(input int which, input int lim);
    n = 0;
    while (n < lim && (which == 0 ? bb : which == 1 ? lg : which == 2 ? ug :
      which == 3 ? sf : which == 4 ? fbc : which == 5 ? slp : shf) !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) check(which, 32'hffff);
  endtask
  task automatic report_and_stop;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog just above the summed wait limits of all scenarios
  initial begin
    #600000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0);
      check(q, mdl[i]);
    end
    wb(1'b0, 8'h2c, 32'h0);
    check(q, 32'h0);
    seed = lfsr(lfsr(seed));
    wb(1'b1, `SBC_BURST_PEAK, {16'h0000, seed} & 32'h00ff_00ff);
    wb(1'b1, `SBC_PULSES, 32'h0032_0010);
    wb(1'b0, `SBC_BURST_PEAK, 32'h0);
    check(q, mdl[8]);
    $display("registers done");
    // a failed condition falls back to supply regulation
    nov <= 1'b0;
    sup <= 1'b1;
    await(0, 3000);
    check(bb, 1'b1);
    $display("fallback done");
    // shorted output: no zero crossing ever arrives
    nov <= 1'b1;
    rsq <= 1'b1;
    @(posedge clk);
    rsq <= 1'b0;
    await(1, 3000);
    n = 0;
    while (lg === 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    check(n, 16);
    await(2, 50);
    check(peak, mdl[4][9:0]);
    lk = 1'b1;
    wb(1'b1, `SBC_PULSES, 32'h0);
    lk = 1'b0;
    wb(1'b0, `SBC_PULSES, 32'h0);
    check(q, mdl[1]);
    hs0 = n_hs;
    await(3, 20000);
    check(n_hs - hs0 >= 32'(mdl[3][7:0]), 1'b1);
    $display("short done");
    // healthy output rises past both thresholds, feedback takes over, then light load
    zc_en <= 1'b1;
    zcd_lvl <= 10'h200;
    fbsp <= 10'h000;
    rsq <= 1'b1;
    @(posedge clk);
    rsq <= 1'b0;
    await(4, 20000);
    check(continuous_resonant_scheme, 1'b1);
    check(sf, 1'b0);
    @(posedge clk);
    check(peak, fbsp);
    hv0 = n_hv;
    fb <= 10'h010;
    await(5, 5000);
    repeat (3) @(posedge clk);
    check(n_hv - hv0, 1);
    check(peak, mdl[8][9:0] + mdl[8][25:16]);
    check(ug, 1'b0);
    $display("burst entry done");
    // shorted shunt: the on-time limit from the input level ends the first upper pulse
    fb <= 10'h100;
    vin <= 10'h1f0;
    wb(1'b1, `SBC_HSMAX, 32'h0010_0022);
    kick();
    await(2, 200);
    n = 0;
    while (ug === 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    check(n, mdl[9][15:0] - ((vin * mdl[9][23:16]) >> 8) + 1);
    check(shf, 1'b1);
    check(tf, 1'b0);
    $display("shunt done");
    // overtemperature seen after the first three conditions: fall back, no pulse
    ot <= 1'b0;
    kick();
    await(0, 100);
    check(lg, 1'b0);
    $display("overtemp done");
    report_and_stop();
  end
endmodule
`default_nettype wire
